// ### rtl/bxa_defines.svh
`ifndef BXA_DEFINES_SVH
`define BXA_DEFINES_SVH

// configuration space offsets
`define BXA_LAT_OFF 8'h0D
`define BXA_STAT_OFF 8'h40

// latency timer start values per bus mode
`define BXA_LAT_REG 8'h40
`define BXA_LAT_CONV 8'h00

// clocks of address drive before frame on a configuration start
`define BXA_CFG_SETUP 3'h4
// consecutive idle granted clocks before driving a parked bus
`define BXA_PARK_IDLE 3'h4
// granted idle clocks seen before giving up the request
`define BXA_REQ_GIVEUP 3'h4
// clocks after reset release before the mode strap is taken
`define BXA_MODE_WAIT 2'h2

`endif

// ### rtl/bxa_initiator.sv
`timescale 1ns/1ns
`include "bxa_defines.svh"

// Functional notes
// R01 - config start drives address four clocks before frame; others together
// R02 - request may rise or fall any clock; no drop needed after stop
// R03 - granted on idle bus: start or drop request by sixth clock after
// R04 - may start at N with grant and idle bus seen at N-2
// R05 - may also start after frame high, irdy low at N-3
// R06 - start allowed though grant already removed at N-1
// R07 - own grant on last clock lets next transaction follow one idle clock
// R08 - no fast back-to-back; one idle clock between transactions always
// R09 - internal sources share one request/grant pair, fairly rotated
// R10 - arbiter asserts at most one grant at a time
// R11 - arbiter holds grant five idle clocks for configuration starts
// R12 - arbiter may lock out device ignoring grant through N+6
// R13 - arbiter waits one clock between removing and giving grants
// R14 - arbiter may park grant on a non-requesting initiator
// R15 - parked four idle clocks: drive address lines by sixth, parity next
// R16 - parked device releases bus lines two clocks after grant removal
// R17 - parked initiator runs one transaction without request; more need it
// R18 - parked initiator may start two clocks after any granted clock
// R19 - arbiter parks only on devices seen requesting
// R20 - arbiter keeps bus idle for hot-plug initialization pattern
// R21 - latency timer resets to 64 in registered mode, else zero
// R22 - expired timer without grant disconnects at next or following boundary
// R23 - timer reloads each start, counts down while frame asserted
// R24 - request and grant pass straight through flip-flops
// R25 - arbiter rotates priority so every requester is served
module bxa_initiator import bxa_pkg::*; (
  input wire logic clk_in, // bus clock
  input wire logic nrst_in, // async reset, active low
  input wire logic gnt_n_in, // grant pin
  input wire logic frame_n_in, // frame pin as seen on the bus
  input wire logic irdy_n_in, // initiator ready pin
  input wire logic pcix_mode_in, // registered mode strap from init pattern
  input wire logic [1:0] src_req_in, // pending transaction per source
  input wire logic [1:0] src_cfg_in, // pending one is a configuration
  input wire logic src_done_in, // data engine finished the burst
  input wire logic adb_in, // disconnect boundary reached this clock
  input wire logic adb_near_in, // under four data phases to boundary
  input wire logic cfg_wr_in, // configuration write strobe
  input wire logic cfg_rd_in, // configuration read strobe
  input wire logic [7:0] cfg_addr_in, // configuration byte offset
  input wire logic [7:0] cfg_wdata_in, // configuration write data
  output logic req_n_out, // request pin
  output logic frame_n_out, // frame drive value
  output logic frame_oe_out, // frame output enable
  output logic ad_oe_out, // address/data and byte enable enable
  output logic par_oe_out, // parity output enable
  output logic start_out, // transaction start pulse
  output logic [1:0] src_sel_out, // source owning the bus
  output logic disconnect_out, // timer disconnect pulse
  output logic pcix_mode_out, // captured bus mode
  output logic [7:0] cfg_rdata_out // configuration read data
);

  bxa_regs_s r;
  bxa_regs_s next_r;
  logic [1:0] pick;
  logic take;
  logic idle_q;
  logic go;
  logic parked;
  logic solo;
  logic want;
  logic expired;
  logic tmr_disc;

  //////////////////////////////////////////////////////////////////////////
  // internal source arbitration

  bxa_src_arb u_arb (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .req_in(src_req_in),
    .take_in(take),
    .pick_out(pick)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_r = r;
    // bus inputs registered once, then one more delay stage
    next_r.q = '{gnt_n: gnt_n_in, frame_n: frame_n_in,
                 irdy_n: irdy_n_in}; // R24
    next_r.d1 = r.q;
    idle_q = r.q.frame_n && r.q.irdy_n;
    expired = (r.lat_cnt == 8'h00);
    // start window from the grant two clocks back
    go = !r.q.gnt_n && (idle_q || (r.d1.frame_n && !r.d1.irdy_n) ||
         r.last) && (r.st == BXA_IDLE); // R04 R05 R06 R07 R08 R18
    take = go && (src_req_in != 2'h0);
    parked = !r.q.gnt_n && idle_q && r.req_n;
    solo = (src_req_in == 2'h1) || (src_req_in == 2'h2);
    tmr_disc = expired && r.q.gnt_n && adb_in && !r.skip; // R22
    next_r.start = 1'b0;
    next_r.disc = 1'b0;
    next_r.last = (r.st == BXA_END);
    next_r.backoff = 1'b0;

    // mode strap synchronised then caught once after reset release
    next_r.msync = {r.msync[0], pcix_mode_in};
    if (!r.mdone) begin
      if (r.mwait == `BXA_MODE_WAIT) begin
        next_r.mdone = 1'b1;
        next_r.pcix = r.msync[1];
        next_r.lat_reg = r.msync[1] ? `BXA_LAT_REG : `BXA_LAT_CONV; // R21
      end else begin
        next_r.mwait = r.mwait + 2'h1;
      end
    end

    // clocks granted on an idle bus while asking and not starting
    if (!r.q.gnt_n && idle_q && !r.req_n && r.st == BXA_IDLE && !take) begin
      next_r.gnt_cnt = r.gnt_cnt + 3'h1;
    end else begin
      next_r.gnt_cnt = 3'h0;
    end
    if (r.gnt_cnt == `BXA_REQ_GIVEUP) begin
      next_r.backoff = 1'b1; // R03
      next_r.gnt_cnt = 3'h0;
    end

    // request: any pending work, except a lone transaction when parked
    want = (src_req_in != 2'h0) && !(parked && solo); // R02 R17
    next_r.req_n = !(want && !next_r.backoff && !r.backoff); // R03 R24

    // parked bus drive after four idle granted clocks
    if (!r.q.gnt_n && idle_q && r.st == BXA_IDLE) begin
      if (r.park_cnt != `BXA_PARK_IDLE) begin
        next_r.park_cnt = r.park_cnt + 3'h1;
      end
    end else begin
      next_r.park_cnt = 3'h0;
    end
    if (r.st == BXA_IDLE) begin
      // drops two clocks after grant pin goes high
      next_r.ad_oe = (r.park_cnt == `BXA_PARK_IDLE) && !r.q.gnt_n; // R15 R16
    end
    next_r.par_oe = r.ad_oe; // R15

    // transaction sequencer
    case (r.st)
      BXA_IDLE: begin
        next_r.frame_oe = 1'b0;
        next_r.frame_n = 1'b1;
        if (take) begin
          next_r.start = 1'b1;
          next_r.sel = pick;
          next_r.ad_oe = 1'b1;
          next_r.lat_cnt = r.lat_reg; // R23
          next_r.skip = 1'b0;
          next_r.frame_oe = 1'b1;
          if ((src_cfg_in & pick) != 2'h0) begin
            next_r.st = BXA_SETUP; // R01
            next_r.setup_cnt = 3'h1;
          end else begin
            next_r.st = BXA_DATA;
            next_r.frame_n = 1'b0; // R01
          end
        end
      end
      BXA_SETUP: begin
        if (r.setup_cnt == `BXA_CFG_SETUP) begin
          next_r.st = BXA_DATA;
          next_r.frame_n = 1'b0; // R01
          next_r.lat_cnt = r.lat_reg; // R23
        end else begin
          next_r.setup_cnt = r.setup_cnt + 3'h1;
        end
      end
      BXA_DATA: begin
        if (!expired) begin
          next_r.lat_cnt = r.lat_cnt - 8'h01; // R23
          if (r.lat_cnt == 8'h01 && adb_near_in) begin
            next_r.skip = 1'b1; // R22
          end
        end else if (adb_in && r.skip) begin
          next_r.skip = 1'b0; // R22
        end
        if (src_done_in || tmr_disc) begin
          next_r.st = BXA_END;
          next_r.frame_n = 1'b1;
          next_r.disc = tmr_disc && !src_done_in; // R22
        end
      end
      BXA_END: begin
        next_r.st = BXA_IDLE; // R08
        next_r.frame_oe = 1'b0;
        next_r.ad_oe = 1'b0;
      end
      default: begin
        next_r.st = BXA_IDLE;
      end
    endcase

    // configuration space access
    if (cfg_wr_in && cfg_addr_in == `BXA_LAT_OFF) begin
      next_r.lat_reg = cfg_wdata_in;
    end
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        `BXA_LAT_OFF: next_r.rdata = r.lat_reg;
        `BXA_STAT_OFF: next_r.rdata = {2'h0, r.skip, parked, r.pcix,
                                       r.st};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
      r.q <= '{gnt_n: 1'b1, frame_n: 1'b1, irdy_n: 1'b1};
      r.d1 <= '{gnt_n: 1'b1, frame_n: 1'b1, irdy_n: 1'b1};
      r.req_n <= 1'b1;
      r.frame_n <= 1'b1;
      r.lat_cnt <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  assign req_n_out = r.req_n;
  assign frame_n_out = r.frame_n;
  assign frame_oe_out = r.frame_oe;
  assign ad_oe_out = r.ad_oe;
  assign par_oe_out = r.par_oe;
  assign start_out = r.start;
  assign src_sel_out = r.sel;
  assign disconnect_out = r.disc;
  assign pcix_mode_out = r.pcix;
  assign cfg_rdata_out = r.rdata;

endmodule : bxa_initiator

// ### rtl/bxa_pkg.sv
package bxa_pkg;

  // initiator sequencer states
  typedef enum logic [2:0] {
    BXA_IDLE = 3'b000,
    BXA_SETUP = 3'b001,
    BXA_DATA = 3'b010,
    BXA_END = 3'b011
  } bxa_state_e;

  // registered and delayed bus inputs, all active low
  typedef struct packed {
    logic gnt_n;
    logic frame_n;
    logic irdy_n;
  } bxa_bus_s;

  // internal source arbiter state
  typedef struct packed {
    logic last;
  } bxa_arb_s;

  // full state of the initiator
  typedef struct packed {
    bxa_state_e st;
    bxa_bus_s q;
    bxa_bus_s d1;
    logic last;
    logic [2:0] setup_cnt;
    logic [2:0] gnt_cnt;
    logic [2:0] park_cnt;
    logic backoff;
    logic [7:0] lat_reg;
    logic [7:0] lat_cnt;
    logic skip;
    logic [1:0] msync;
    logic [1:0] mwait;
    logic mdone;
    logic pcix;
    logic req_n;
    logic frame_n;
    logic frame_oe;
    logic ad_oe;
    logic par_oe;
    logic start;
    logic [1:0] sel;
    logic disc;
    logic [7:0] rdata;
  } bxa_regs_s;

endpackage : bxa_pkg

// ### rtl/bxa_src_arb.sv
`timescale 1ns/1ns
// rotating priority between the two internal initiator sources
module bxa_src_arb import bxa_pkg::*; (
  input wire logic clk_in, // bus clock
  input wire logic nrst_in, // async reset, active low
  input wire logic [1:0] req_in, // source requests
  input wire logic take_in, // pick consumed this clock
  output logic [1:0] pick_out // one-hot chosen source
);

  bxa_arb_s r;
  bxa_arb_s next_r;

  // choose the source not served last when both wait
  always_comb begin
    next_r = r;
    pick_out = 2'h0;
    if (req_in == 2'h3) begin
      pick_out = r.last ? 2'h1 : 2'h2; // R09
    end else begin
      pick_out = req_in;
    end
    if (take_in) begin
      next_r.last = pick_out[1];
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : bxa_src_arb

// ### verification/bxa_arb_model.sv
`timescale 1ns/1ns
// central arbiter as one device sees it
module bxa_arb_model (
  input wire logic clk_in, // bus clock
  input wire logic nrst_in, // reset, active low
  input wire logic req_n_in, // request pin
  input wire logic park_in, // parking allowed
  output logic gnt_n_out // grant pin
);
  logic req_q, seen, gap, want;
  ////////////////////////////////
  // grant a request, or park once the device has requested
  // lone requester here, so rotation always lands on it
  assign want = req_q || (park_in && seen);
  // one grant only; a removed grant waits a clock to return
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // no grant around reset keeps the bus idle for the init pattern
      req_q <= 1'h0;
      seen <= 1'h0;
      gap <= 1'h0;
      gnt_n_out <= 1'h1;
    end else begin
      req_q <= !req_n_in;
      seen <= seen || req_q;
      gap <= !gnt_n_out && !want;
      // grant held while wanted, so idle grants last five clocks and more;
      // the device is never locked out as broken
      gnt_n_out <= !(want && (!gnt_n_out || !gap));
    end
  end
endmodule : bxa_arb_model

// ### verification/bxa_initiator_props.sv
`timescale 1ns/1ns
module bxa_initiator_props (
  input wire logic clk_in, // clock
  input wire logic nrst_in, // reset
  input wire logic gnt_n_in, // grant
  input wire logic frame_n_in, // bus frame
  input wire logic irdy_n_in, // bus ready
  input wire logic adb_in, // boundary
  input wire logic req_n_out, // request
  input wire logic frame_n_out, // frame
  input wire logic frame_oe_out, // frame enable
  input wire logic ad_oe_out, // bus enable
  input wire logic par_oe_out, // parity enable
  input wire logic start_out, // start
  input wire logic disconnect_out // disconnect
);
  logic [2:0] idle_cnt;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////
  // granted idle clocks at the pins, saturating
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_cnt <= 3'h0;
    end else if (gnt_n_in || !frame_n_in || !irdy_n_in) begin
      idle_cnt <= 3'h0;
    end else if (idle_cnt != 3'h7) begin
      idle_cnt <= idle_cnt + 3'h1;
    end
  end
  // granted on an idle bus while requesting
  sequence s_wait;
    !gnt_n_in && frame_n_in && irdy_n_in && !req_n_out && !frame_oe_out;
  endsequence
  AST_CFG_SETUP: assert property (
    start_out && frame_n_out |-> ##1 frame_n_out [*3] ##1 !frame_n_out)
    else $error("config frame timing");
  AST_START_GNT: assert property (
    start_out |-> !$past(gnt_n_in, 2))
    else $error("start without grant");
  AST_GIVEUP: assert property (
    s_wait |-> ##[0:6] (req_n_out || frame_oe_out || gnt_n_in))
    else $error("grant held unused");
  AST_IDLE_GAP: assert property (
    $fell(frame_oe_out) |-> !start_out)
    else $error("no idle clock");
  AST_PARK_DRIVE: assert property (
    idle_cnt == 3'h7 |-> ad_oe_out)
    else $error("parked bus undriven");
  AST_PARK_PAR: assert property (
    $rose(ad_oe_out) |-> !par_oe_out ##1 par_oe_out)
    else $error("parity enable timing");
  AST_PARK_RELEASE: assert property (
    $rose(gnt_n_in) && ad_oe_out && !frame_oe_out
      |-> ##3 !(ad_oe_out && !frame_oe_out))
    else $error("parked bus kept");
  AST_DISCONNECT: assert property (
    disconnect_out |-> $past(adb_in) ##[0:1] (frame_oe_out && frame_n_out))
    else $error("disconnect timing");
  COV_CFG: cover property (start_out && frame_n_out);
  COV_DISC: cover property (disconnect_out);
  COV_PARK: cover property (ad_oe_out && !frame_oe_out);
endmodule : bxa_initiator_props
bind bxa_initiator bxa_initiator_props i_props (.clk_in(clk_in),
  .nrst_in(nrst_in), .gnt_n_in(gnt_n_in), .frame_n_in(frame_n_in),
  .irdy_n_in(irdy_n_in), .adb_in(adb_in), .req_n_out(req_n_out),
  .frame_n_out(frame_n_out), .frame_oe_out(frame_oe_out),
  .ad_oe_out(ad_oe_out), .par_oe_out(par_oe_out),
  .start_out(start_out), .disconnect_out(disconnect_out));

// ### verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  typedef struct {logic [7:0] a, d, e; logic w;} bxa_row_s;
  // offset, write data, expected read, write first
  bxa_row_s rows [4] = '{'{8'h0D, 8'h00, 8'h40, 1'h0},
    '{8'h40, 8'h00, 8'h08, 1'h0},
    '{8'h0E, 8'hAA, 8'h00, 1'h1}, '{8'h0D, 8'h03, 8'h03, 1'h1}};
  logic clk_in = 1'h0, nrst_in = 1'h0, irdy_n_in = 1'h1;
  logic pcix_mode_in = 1'h1, src_done_in = 1'h0, park = 1'h0;
  logic adb_in = 1'h0, adb_near_in = 1'h0;
  logic cfg_wr_in = 1'h0, cfg_rd_in = 1'h0;
  logic [1:0] src_req_in = 2'h0, src_cfg_in = 2'h0;
  logic [7:0] cfg_addr_in = 8'h00, cfg_wdata_in = 8'h00;
  logic [1:0] src_sel_out, s1;
  logic [7:0] cfg_rdata_out;
  logic gnt_n_in, req_n_out, frame_n_out, frame_oe_out, ad_oe_out;
  logic par_oe_out, start_out, disconnect_out, pcix_mode_out;
  int err_count = 0, n_tests = 0, i;
  int cnt [2];
  // own frame while driving, pulled up otherwise
  wire logic frame_n_in = frame_oe_out ? frame_n_out : 1'h1;
  bxa_initiator i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .gnt_n_in(gnt_n_in), .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in),
    .pcix_mode_in(pcix_mode_in), .src_req_in(src_req_in),
    .src_cfg_in(src_cfg_in), .src_done_in(src_done_in), .adb_in(adb_in),
    .adb_near_in(adb_near_in), .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in),
    .cfg_wdata_in(cfg_wdata_in), .req_n_out(req_n_out),
    .frame_n_out(frame_n_out), .frame_oe_out(frame_oe_out),
    .ad_oe_out(ad_oe_out), .par_oe_out(par_oe_out),
    .start_out(start_out), .src_sel_out(src_sel_out),
    .disconnect_out(disconnect_out), .pcix_mode_out(pcix_mode_out),
    .cfg_rdata_out(cfg_rdata_out));
  bxa_arb_model i_arb (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_n_in(req_n_out), .park_in(park), .gnt_n_out(gnt_n_in));
  ////////////////////////////////
  // clock and watchdog
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #20000;
    err_count++;
    final_report;
  end
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic clks(input int n);
    repeat (n) @(negedge clk_in);
  endtask : clks
  task automatic wait_start;
    for (i = 0; i < 40 && start_out !== 1'h1; i++) begin
      clks(1);
    end
    chk(start_out, 1'h1);
  endtask : wait_start
  task automatic done_after(input int n);
    clks(n);
    src_done_in = 1'h1;
    clks(1);
    src_done_in = 1'h0;
  endtask : done_after
  task automatic cfg(input bxa_row_s r);
    cfg_addr_in = r.a;
    cfg_wdata_in = r.d;
    cfg_wr_in = r.w;
    clks(1);
    cfg_wr_in = 1'h0;
    cfg_rd_in = 1'h1;
    clks(1);
    cfg_rd_in = 1'h0;
    chk(cfg_rdata_out, r.e);
  endtask : cfg
  task automatic final_report;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    clks(16);
    chk({req_n_out, ad_oe_out, frame_oe_out}, 8'h04);
    nrst_in = 1'h1;
    clks(5);
    chk(pcix_mode_out, 1'h1);
    foreach (rows[k]) begin
      cfg(rows[k]);
    end
    src_req_in = 2'h3;
    wait_start;
    s1 = src_sel_out;
    src_req_in = src_req_in & ~s1;
    chk(frame_n_out, 1'h0);
    done_after(3);
    wait_start;
    chk(src_sel_out, s1 ^ 2'h3);
    src_req_in = 2'h0;
    done_after(2);
    park = 1'h1;
    src_cfg_in = 2'h1;
    src_req_in = 2'h1;
    wait_start;
    src_req_in = 2'h0;
    chk(frame_n_out, 1'h1);
    clks(4);
    chk(frame_n_out, 1'h0);
    src_cfg_in = 2'h0;
    done_after(1);
    // parked start, then timer disconnect with and without a skip
    for (int k = 0; k < 2; k++) begin
      park = 1'h1;
      clks(10);
      chk(par_oe_out, 1'h1);
      src_req_in = 2'h1;
      wait_start;
      chk(req_n_out, 1'h1);
      src_req_in = 2'h0;
      park = 1'h0;
      adb_in = 1'h1;
      adb_near_in = k[0];
      for (i = 0; i < 20 && disconnect_out !== 1'h1; i++) begin
        clks(1);
      end
      cnt[k] = i;
      adb_in = 1'h0;
      adb_near_in = 1'h0;
      clks(4);
      chk(frame_oe_out, 1'h0);
    end
    chk(8'(cnt[1]), 8'(cnt[0] + 1));
    park = 1'h1;
    clks(10);
    park = 1'h0;
    clks(4);
    chk(ad_oe_out, 1'h0);
    final_report;
  end
endmodule : testbench
